// ---- src/uart_irq_consts.svh ----
// register offsets, field positions, reset values and status codes for the
// uart interrupt prioritizer; assumes a 32-bit word-aligned apb register map
`ifndef UART_IRQ_CONSTS_SVH
`define UART_IRQ_CONSTS_SVH

`define IRQ_OFF_ENABLE 12'h000
`define IRQ_OFF_STATUS 12'h004
`define IRQ_OFF_FIFO_CTRL 12'h008
`define IRQ_OFF_ENH_FUNC 12'h00C
`define IRQ_OFF_LINE_STATUS 12'h010
`define IRQ_OFF_MODEM_STATUS 12'h014
`define IRQ_OFF_RX_DATA 12'h018
`define IRQ_OFF_TX_DATA 12'h01C
`define IRQ_OFF_EVENT 12'h020

`define IRQ_ENABLE_RESET 8'h00
`define IRQ_FIFO_CTRL_RESET 8'h00
`define IRQ_ENH_FUNC_RESET 8'h00

`define IRQ_EN_RX 0
`define IRQ_EN_TX 1
`define IRQ_EN_LINE 2
`define IRQ_EN_MODEM 3
`define IRQ_EN_SLEEP 4
`define IRQ_EN_XOFF 5
`define IRQ_EN_RTS 6
`define IRQ_EN_CTS 7
`define IRQ_FCR_ENABLE 0
`define IRQ_FCR_WAKE 3
`define IRQ_EFR_ENHANCED 4
`define IRQ_EFR_AUTO_RTS 6
`define IRQ_EFR_AUTO_CTS 7
`define IRQ_ENHANCED_MODE_SELECT_FIFO_ERR 6

`define IRQ_CODE_LINE 6'h06
`define IRQ_CODE_TIMEOUT 6'h0C
`define IRQ_CODE_RX 6'h04
`define IRQ_CODE_TX 6'h02
`define IRQ_CODE_MODEM 6'h00
`define IRQ_CODE_FLOWCHAR 6'h10
`define IRQ_CODE_CTSRTS 6'h20
`define IRQ_CODE_NONE 6'h01

`define IRQ_TRIG_L0 6'd8
`define IRQ_TRIG_L1 6'd16
`define IRQ_TRIG_L2 6'd24
`define IRQ_TRIG_L3 6'd28

// timeout span: four characters plus twelve bit times, counted in bit ticks
`define IRQ_TIMEOUT_CHARS 4
`define IRQ_TIMEOUT_BITS 12

`endif

// ---- src/uart_irq_pkg.sv ----
// types shared by the uart interrupt prioritizer
// assumes uart_irq_consts.svh is available on the include path
package uart_irq_pkg;

  // receive and transmit status from the serial datapath
  typedef struct packed {
    logic [5:0] rx_level;
    logic rx_push;
    logic rx_overrun;
    logic [2:0] head_err;
    logic fifo_err;
    logic tx_hold_empty;
    logic tx_all_empty;
  } line_in_t;

  typedef enum logic [1:0] {
    SLEEP_AWAKE = 2'b00,
    SLEEP_ASLEEP = 2'b01
  } sleep_state_t;

endpackage : uart_irq_pkg

// ---- src/uart_interrupt_prioritizer.sv ----
// interrupt enable, prioritised interrupt status and line status of a uart
// with 32-entry fifos; apb slave, datapath reaches it through level/event pins
// assumes datapath inputs are synchronous to i_ref_clk
//
// Functional notes
// - fifo and rx enable: rx interrupt while fill at or above trigger
// - data ready bit follows non-empty receive fifo
// - enables 0-3 zero with fifo on gives polled mode via line status
// - line status: latched line error, head error type, tx empty, all empty, fifo error
// - enable bit 0 gates receive ready interrupt, fifo or holding mode
// - enable bit 1 gates transmit ready, raised at once if already empty
// - enable bit 2 gates line status: overrun at once, errors by mode
// - enable bit 3 gates modem interrupt from any of four change bits
// - upper enable bits act only with enhanced bit 4 set
// - all enable bits reset to zero
// - cts or rts rising edge under auto control raises flow edge source
// - timeout after four chars plus twelve bits, cleared by data read
// - transmit ready cleared by status read or transmit data write
// - line source cleared by line status read; rx by level drop
// - flow char cleared by status read, special also by next character
// - modem and edge cleared by modem read; wake cleared by status read
// - six-bit code priority: line, timeout, rx, tx, modem, char, edge, none
// - status read reports highest pending only; it also clears lower tx and char, and wake, others stay queued
// - status bit 0 low while a coded source is pending, high when idle or only wake is pending, resets high
// - status bits 4 and 5 flag char match and cts/rts edge when enhanced
// - status bits 7:6 both follow fifo enable
// - fifo control bit 0 enables fifos, resets to off
// - receive trigger 8, 16, 24 or 28 by fifo control bits 7:6
`timescale 1ns/1ps
`include "uart_irq_consts.svh"

module uart_interrupt_prioritizer
  import uart_irq_pkg::*;
#(
  parameter int unsigned TIMEOUT_TICKS_W = 10
) (
  input wire logic i_ref_clk,
  input wire logic i_rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire line_in_t i_line,
  input wire logic i_bit_tick,
  input wire logic [3:0] i_modem_delta,
  input wire logic i_xon_xoff_match,
  input wire logic i_special_match,
  input wire logic i_cts_level,
  input wire logic i_rts_level,
  input wire logic i_wake_event,
  input wire logic [7:0] i_rx_char,
  input wire logic [5:0] i_tx_trigger,
  output logic o_rx_read,
  output logic o_tx_write,
  output logic [7:0] o_tx_char,
  output logic o_irq,
  output logic o_sleep_en
);

  // ***********************************************************
  // bus decode
  // ***********************************************************
  logic acc;
  logic wr;
  logic rd;
  logic known;
  assign acc = psel & penable;
  assign wr = acc & pwrite;
  assign rd = acc & ~pwrite;
  assign pready = 1'b1;
  assign known = (paddr <= `IRQ_OFF_EVENT) && (paddr[1:0] == 2'b00);
  assign pslverr = acc & ~known;

  function automatic logic hit(input logic [11:0] a, input logic [11:0] off);
    hit = (a == off);
  endfunction : hit

  logic rd_status;
  logic rd_line;
  logic rd_modem;
  logic rd_data;
  logic wr_data;
  assign rd_status = rd & hit(paddr, `IRQ_OFF_STATUS);
  assign rd_line = rd & hit(paddr, `IRQ_OFF_LINE_STATUS);
  assign rd_modem = rd & hit(paddr, `IRQ_OFF_MODEM_STATUS);
  assign rd_data = rd & hit(paddr, `IRQ_OFF_RX_DATA);
  assign wr_data = wr & hit(paddr, `IRQ_OFF_TX_DATA);
  assign o_rx_read = rd_data;
  assign o_tx_write = wr_data;

  // ***********************************************************
  // control registers
  // ***********************************************************
  logic [7:0] enable_r;
  logic [7:0] fifo_ctrl_r;
  logic [7:0] enh_r;
  logic [7:0] enhanced_mode_select_r;
  logic [7:0] tx_char_r;

  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      enable_r <= `IRQ_ENABLE_RESET;
      fifo_ctrl_r <= `IRQ_FIFO_CTRL_RESET;
      enh_r <= `IRQ_ENH_FUNC_RESET;
      enhanced_mode_select_r <= 8'h00;
      tx_char_r <= 8'h00;
    end else if (wr) begin
      if (hit(paddr, `IRQ_OFF_ENABLE)) begin
        enable_r <= pwdata[7:0];
      end
      if (hit(paddr, `IRQ_OFF_FIFO_CTRL)) begin
        fifo_ctrl_r <= pwdata[7:0];
      end
      if (hit(paddr, `IRQ_OFF_ENH_FUNC)) begin
        enh_r <= pwdata[7:0];
      end
      if (hit(paddr, `IRQ_OFF_EVENT)) begin
        enhanced_mode_select_r <= pwdata[7:0];
      end
      if (wr_data) begin
        tx_char_r <= pwdata[7:0];
      end
    end
  end
  assign o_tx_char = tx_char_r;

  logic fifo_on;
  logic enh_on;
  logic [7:0] en_eff;
  assign fifo_on = fifo_ctrl_r[`IRQ_FCR_ENABLE];
  assign enh_on = enh_r[`IRQ_EFR_ENHANCED];
  // upper enables are masked unless enhanced functions are unlocked
  assign en_eff = {enable_r[7:4] & {4{enh_on}}, enable_r[3:0]};
  assign o_sleep_en = en_eff[`IRQ_EN_SLEEP];

  function automatic logic [5:0] trig_level(input logic [1:0] sel);
    unique case (sel)
      2'b00: trig_level = `IRQ_TRIG_L0;
      2'b01: trig_level = `IRQ_TRIG_L1;
      2'b10: trig_level = `IRQ_TRIG_L2;
      2'b11: trig_level = `IRQ_TRIG_L3;
    endcase
  endfunction : trig_level

  // ***********************************************************
  // level sources
  // ***********************************************************
  logic rx_level_hit;
  logic data_ready;
  // non-fifo mode has a one-deep holding register: any fill counts
  assign rx_level_hit = fifo_on ? (i_line.rx_level >= trig_level(fifo_ctrl_r[7:6]))
                                : (i_line.rx_level != 6'd0);
  assign data_ready = (i_line.rx_level != 6'd0);

  // ***********************************************************
  // sticky sources
  // ***********************************************************
  logic line_r;
  logic tx_r;
  logic tx_empty_d;
  logic tx_en_d;
  logic tx_cond;
  logic tx_set;
  logic err_set;

  assign tx_cond = fifo_on ? (i_line.tx_hold_empty || i_tx_trigger == 6'd0)
                           : i_line.tx_hold_empty;
  // raise on becoming empty, or when the enable is turned on while empty
  assign tx_set = (tx_cond & ~tx_empty_d) |
                  (tx_cond & en_eff[`IRQ_EN_TX] & ~tx_en_d);
  // error reporting point chosen by enhanced mode select bit 6
  assign err_set = i_line.rx_overrun |
                   (enhanced_mode_select_r[`IRQ_ENHANCED_MODE_SELECT_FIFO_ERR] ? (i_line.rx_push & i_line.fifo_err)
                                                : (i_line.head_err != 3'b000));

  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      tx_empty_d <= 1'b1;
      tx_en_d <= 1'b0;
    end else begin
      tx_empty_d <= tx_cond;
      tx_en_d <= en_eff[`IRQ_EN_TX];
    end
  end

  // line-status source; a new error wins over a simultaneous clear
  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      line_r <= 1'b0;
    end else if (err_set) begin
      line_r <= 1'b1;
    end else if (rd_line) begin
      line_r <= 1'b0;
    end
  end

  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      tx_r <= 1'b0;
    end else if (tx_set) begin
      tx_r <= 1'b1;
    end else if (rd_status | wr_data) begin
      tx_r <= 1'b0;
    end
  end

  logic [3:0] modem_r;
  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      modem_r <= 4'h0;
    end else begin
      modem_r <= (rd_modem ? 4'h0 : modem_r) | i_modem_delta;
    end
  end

  // flow-control edges, only under automatic control
  logic cts_d;
  logic rts_d;
  logic edge_set;
  logic edge_r;
  assign edge_set = (i_cts_level & ~cts_d & enh_r[`IRQ_EFR_AUTO_CTS] & en_eff[`IRQ_EN_CTS]) |
                    (i_rts_level & ~rts_d & enh_r[`IRQ_EFR_AUTO_RTS] & en_eff[`IRQ_EN_RTS]);
  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      cts_d <= 1'b0;
      rts_d <= 1'b0;
      edge_r <= 1'b0;
    end else begin
      cts_d <= i_cts_level;
      rts_d <= i_rts_level;
      if (edge_set) begin
        edge_r <= 1'b1;
      end else if (rd_modem) begin
        edge_r <= 1'b0;
      end
    end
  end

  logic xon_r;
  logic spec_r;
  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      xon_r <= 1'b0;
      spec_r <= 1'b0;
    end else begin
      if (i_xon_xoff_match) begin
        xon_r <= 1'b1;
      end else if (rd_status) begin
        xon_r <= 1'b0;
      end
      if (i_special_match) begin
        spec_r <= 1'b1;
      end else if (rd_status | i_line.rx_push) begin
        spec_r <= 1'b0;
      end
    end
  end

  logic wake_r;
  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      wake_r <= 1'b0;
    end else if (i_wake_event & fifo_ctrl_r[`IRQ_FCR_WAKE] & enh_on) begin
      wake_r <= 1'b1;
    end else if (rd_status) begin
      wake_r <= 1'b0;
    end
  end

  // ***********************************************************
  // receive timeout
  // ***********************************************************
  // span in bit ticks; char length taken as ten bits, a fixed approximation
  localparam logic [TIMEOUT_TICKS_W-1:0] TIMEOUT_SPAN =
    TIMEOUT_TICKS_W'(`IRQ_TIMEOUT_CHARS * 10 + `IRQ_TIMEOUT_BITS);
  logic [TIMEOUT_TICKS_W-1:0] to_cnt_r;
  logic timeout_r;
  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      to_cnt_r <= '0;
      timeout_r <= 1'b0;
    end else begin
      if (i_line.rx_push | rd_data | ~data_ready) begin
        to_cnt_r <= '0;
      end else if (i_bit_tick && to_cnt_r != TIMEOUT_SPAN) begin
        to_cnt_r <= to_cnt_r + 1'b1;
      end
      if (fifo_on & data_ready & i_bit_tick &&
          to_cnt_r == TIMEOUT_SPAN - 1'b1) begin
        timeout_r <= 1'b1;
      end else if (rd_data) begin
        timeout_r <= 1'b0;
      end
    end
  end

  // ***********************************************************
  // priority encoder
  // ***********************************************************
  logic p_line;
  logic p_to;
  logic p_rx;
  logic p_tx;
  logic p_modem;
  logic p_char;
  logic p_edge;
  logic [5:0] code;
  assign p_line = line_r & en_eff[`IRQ_EN_LINE];
  assign p_to = timeout_r & en_eff[`IRQ_EN_RX];
  assign p_rx = rx_level_hit & en_eff[`IRQ_EN_RX];
  assign p_tx = tx_r & en_eff[`IRQ_EN_TX];
  assign p_modem = (modem_r != 4'h0) & en_eff[`IRQ_EN_MODEM];
  assign p_char = (xon_r | spec_r) & en_eff[`IRQ_EN_XOFF];
  assign p_edge = edge_r & (en_eff[`IRQ_EN_CTS] | en_eff[`IRQ_EN_RTS]);

  always_comb begin
    // only the top pending source is shown; a status read still clears a lower tx or char source
    if (p_line) code = `IRQ_CODE_LINE;
    else if (p_to) code = `IRQ_CODE_TIMEOUT;
    else if (p_rx) code = `IRQ_CODE_RX;
    else if (p_tx) code = `IRQ_CODE_TX;
    else if (p_modem) code = `IRQ_CODE_MODEM;
    else if (p_char) code = `IRQ_CODE_FLOWCHAR;
    else if (p_edge) code = `IRQ_CODE_CTSRTS;
    else code = `IRQ_CODE_NONE;
  end

  logic any_pending;
  assign any_pending = p_line | p_to | p_rx | p_tx | p_modem | p_char | p_edge;

  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      o_irq <= 1'b0;
    end else begin
      o_irq <= any_pending | (wake_r & enh_on & fifo_ctrl_r[`IRQ_FCR_WAKE]);
    end
  end

  // ***********************************************************
  // read data
  // ***********************************************************
  logic [7:0] line_status;
  // polled mode needs no extra logic: status stays readable with enables zero
  assign line_status = {i_line.fifo_err, i_line.tx_all_empty, i_line.tx_hold_empty,
                        i_line.head_err, line_r,
                        data_ready};

  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      prdata <= 32'h0000_0000;
    end else if (psel & ~penable & ~pwrite) begin
      unique case (paddr)
        `IRQ_OFF_ENABLE: prdata <= {24'h000000, enable_r};
        `IRQ_OFF_STATUS: prdata <= {24'h000000, {2{fifo_on}}, code};
        `IRQ_OFF_FIFO_CTRL: prdata <= {24'h000000, fifo_ctrl_r};
        `IRQ_OFF_ENH_FUNC: prdata <= {24'h000000, enh_r};
        `IRQ_OFF_LINE_STATUS: prdata <= {24'h000000, line_status};
        `IRQ_OFF_MODEM_STATUS: prdata <= {28'h0000000, modem_r};
        `IRQ_OFF_RX_DATA: prdata <= {24'h000000, i_rx_char};
        default: prdata <= 32'h0000_0000;
      endcase
    end
  end

  // ***********************************************************
  // checks
  // ***********************************************************
  status_idle_a: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    !(any_pending | wake_r) |-> code == `IRQ_CODE_NONE)
    else $error("idle status code wrong");
  enable_mask_a: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    en_eff == 8'h00 && !fifo_ctrl_r[`IRQ_FCR_WAKE] |=> !o_irq)
    else $error("irq with all enables off");
  line_first_a: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    p_line |-> code == `IRQ_CODE_LINE)
    else $error("line source not top priority");
  tx_clear_a: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    tx_r && wr_data && !tx_set |=> !tx_r)
    else $error("tx ready not cleared by write");
  modem_clear_a: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    rd_modem && i_modem_delta == 4'h0 && !edge_set |=> modem_r == 4'h0 && !edge_r)
    else $error("modem read did not clear");
  upper_gate_a: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    !enh_on |-> en_eff[7:4] == 4'h0)
    else $error("upper enables active without enhanced bit");
  rx_trigger_a: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    fifo_on && en_eff[0] && (i_line.rx_level >= `IRQ_TRIG_L3 ||
    (fifo_ctrl_r[7:6] == 2'b00 && i_line.rx_level >= `IRQ_TRIG_L0)) |-> p_rx)
    else $error("rx trigger not raised");
  line_sticky_a: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    err_set |=> line_r)
    else $error("error not latched");

endmodule : uart_interrupt_prioritizer

// ---- bench/uart_line_model.sv ----
// behavioural receive fifo level and transmit holding model for the prioritizer
// assumes push, overrun and pop requests arrive as one-cycle pulses on i_ref_clk
`timescale 1ns/1ps

module uart_line_model
  import uart_irq_pkg::*;
(
  input wire logic i_ref_clk,
  input wire logic i_rst,
  input wire logic i_push,
  input wire logic i_overrun,
  input wire logic i_pop,
  input wire logic i_tx_write,
  input wire logic [2:0] i_head_err,
  output line_in_t o_line,
  output logic [7:0] o_head_char
);
  // ************************************
  // fifo occupancy and transmit state
  // ************************************
  logic [5:0] level_r;
  logic tx_empty_r;

  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      level_r <= 6'h00;
    end else if (i_push && !i_pop && level_r != 6'h20) begin
      level_r <= level_r + 6'h01;
    end else if (i_pop && !i_push && level_r != 6'h00) begin
      level_r <= level_r - 6'h01;
    end
  end

  // no transmitter behind it: once written the holding register stays full
  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      tx_empty_r <= 1'b1;
    end else if (i_tx_write) begin
      tx_empty_r <= 1'b0;
    end
  end

  always_comb begin
    o_line = '0;
    o_line.rx_level = level_r;
    o_line.rx_push = i_push;
    o_line.rx_overrun = i_overrun;
    o_line.head_err = i_head_err;
    o_line.fifo_err = |i_head_err;
    o_line.tx_hold_empty = tx_empty_r;
    o_line.tx_all_empty = tx_empty_r;
  end

  // head character tracks the fill level, changing with every pop that lowers it, so a stale value is not mistaken
  assign o_head_char = {2'h0, level_r} ^ 8'hA5;
endmodule : uart_line_model

// ---- bench/uart_interrupt_prioritizer_test.sv ----
// self-checking bench for the uart interrupt prioritizer
// assumes the line model stands in for the serial datapath
`timescale 1ns/1ps
`include "uart_irq_consts.svh"

`define CHK(got, exp) begin comparisons++; if ((got) !== (exp)) begin bad_count++; \
  $display("FAIL t=%0t got=%h exp=%h", $time, got, exp); end end

module uart_interrupt_prioritizer_test
  import uart_irq_pkg::*;
;
  // ************************************
  // signals
  // ************************************
  logic i_ref_clk = 1'b0, i_rst = 1'b1;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata;
  logic pready, pslverr, o_rx_read, o_tx_write, o_irq, o_sleep_en, err_seen;
  logic push = 1'b0, ovr = 1'b0, tick = 1'b0, xon = 1'b0, special = 1'b0;
  logic cts = 1'b0, rts = 1'b0, wake = 1'b0;
  logic [3:0] mdelta = 4'h0;
  logic [2:0] herr = 3'b000;
  logic [5:0] txfill = 6'h01;
  logic [7:0] o_tx_char, head_char;
  line_in_t line;
  int bad_count = 0, comparisons = 0, cycles = 0;

  uart_interrupt_prioritizer i_uart_interrupt_prioritizer (.i_ref_clk(i_ref_clk),
    .i_rst(i_rst), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .i_line(line),
    .i_bit_tick(tick), .i_modem_delta(mdelta), .i_xon_xoff_match(xon),
    .i_special_match(special), .i_cts_level(cts), .i_rts_level(rts), .i_wake_event(wake),
    .i_rx_char(head_char), .i_tx_trigger(txfill), .o_rx_read(o_rx_read),
    .o_tx_write(o_tx_write), .o_tx_char(o_tx_char), .o_irq(o_irq), .o_sleep_en(o_sleep_en));

  uart_line_model i_uart_line_model (.i_ref_clk(i_ref_clk), .i_rst(i_rst), .i_push(push),
    .i_overrun(ovr), .i_pop(o_rx_read), .i_tx_write(o_tx_write), .i_head_err(herr),
    .o_line(line),
    .o_head_char(head_char));

  initial begin
    forever #20 i_ref_clk = ~i_ref_clk;
  end

  // ************************************
  // bus and stimulus tasks
  // ************************************
  task automatic apb_xfer(input logic wr, input logic [11:0] addr, input logic [31:0] wd,
                          output logic [31:0] rd);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= addr;
    pwdata <= wd;
    @(posedge i_ref_clk);
    penable <= 1'b1;
    do begin
      @(posedge i_ref_clk);
    end while (pready !== 1'b1);
    rd = prdata;
    err_seen = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge i_ref_clk);
  endtask : apb_xfer

  task automatic wr(input logic [11:0] addr, input logic [31:0] wd);
    logic [31:0] rd;
    apb_xfer(1'b1, addr, wd, rd);
  endtask : wr

  task automatic chk_rd(input logic [11:0] addr, input logic [31:0] exp);
    logic [31:0] rd;
    apb_xfer(1'b0, addr, 32'h0, rd);
    `CHK(rd, exp)
  endtask : chk_rd

  task automatic push_n(input int n, input logic with_ovr);
    repeat (n) begin
      push <= 1'b1;
      ovr <= with_ovr;
      @(posedge i_ref_clk);
      push <= 1'b0;
      ovr <= 1'b0;
      @(posedge i_ref_clk);
    end
  endtask : push_n

  // ************************************
  // scenarios
  // ************************************
  task automatic reset_state;
    chk_rd(`IRQ_OFF_ENABLE, 32'h00);
    chk_rd(`IRQ_OFF_STATUS, 32'h01);
    `CHK(o_irq, 1'b0)
    chk_rd(12'h040, 32'h00);
    `CHK(err_seen, 1'b1)
  endtask : reset_state

  task automatic rx_trigger;
    wr(`IRQ_OFF_FIFO_CTRL, 32'h01);
    wr(`IRQ_OFF_ENABLE, 32'h01);
    push_n(7, 1'b0);
    chk_rd(`IRQ_OFF_STATUS, 32'hC1);
    push_n(1, 1'b0);
    chk_rd(`IRQ_OFF_STATUS, 32'hC4);
    `CHK(o_irq, 1'b1)
    chk_rd(`IRQ_OFF_RX_DATA, 32'h000000AD);
    chk_rd(`IRQ_OFF_STATUS, 32'hC1);
    `CHK(o_irq, 1'b0)
    chk_rd(`IRQ_OFF_LINE_STATUS, 32'h61);
  endtask : rx_trigger

  task automatic tx_ready;
    wr(`IRQ_OFF_ENABLE, 32'h03);
    chk_rd(`IRQ_OFF_STATUS, 32'hC2);
    wr(`IRQ_OFF_TX_DATA, 32'h5A);
    `CHK(o_tx_char, 8'h5A)
    chk_rd(`IRQ_OFF_STATUS, 32'hC1);
    chk_rd(`IRQ_OFF_LINE_STATUS, 32'h01);
    // transmit fifo fill drops to zero: ready is raised again
    txfill <= 6'h00;
    @(posedge i_ref_clk);
    chk_rd(`IRQ_OFF_STATUS, 32'hC2);
    chk_rd(`IRQ_OFF_STATUS, 32'hC1);
  endtask : tx_ready

  // overrun on top of a trigger crossing, then a modem change queued behind both
  task automatic priority_chain;
    wr(`IRQ_OFF_ENABLE, 32'h0F);
    push_n(1, 1'b1);
    mdelta <= 4'h1;
    @(posedge i_ref_clk);
    mdelta <= 4'h0;
    chk_rd(`IRQ_OFF_STATUS, 32'hC6);
    chk_rd(`IRQ_OFF_LINE_STATUS, 32'h03);
    chk_rd(`IRQ_OFF_STATUS, 32'hC4);
    chk_rd(`IRQ_OFF_RX_DATA, 32'h000000AD);
    chk_rd(`IRQ_OFF_STATUS, 32'hC0);
    chk_rd(`IRQ_OFF_MODEM_STATUS, 32'h01);
    chk_rd(`IRQ_OFF_STATUS, 32'hC1);
  endtask : priority_chain

  task automatic rx_timeout;
    tick <= 1'b1;
    repeat (60) @(posedge i_ref_clk);
    tick <= 1'b0;
    chk_rd(`IRQ_OFF_STATUS, 32'hCC);
    chk_rd(`IRQ_OFF_RX_DATA, 32'h000000A2);
    chk_rd(`IRQ_OFF_STATUS, 32'hC1);
  endtask : rx_timeout

  // head error held, then dropped; then errors gated to fifo entry; then polled mode
  task automatic line_errors;
    wr(`IRQ_OFF_ENABLE, 32'h04);
    herr <= 3'b100;
    @(posedge i_ref_clk);
    chk_rd(`IRQ_OFF_STATUS, 32'hC6);
    chk_rd(`IRQ_OFF_LINE_STATUS, 32'h93);
    herr <= 3'b000;
    chk_rd(`IRQ_OFF_LINE_STATUS, 32'h03);
    chk_rd(`IRQ_OFF_STATUS, 32'hC1);
    wr(`IRQ_OFF_EVENT, 32'h40);
    herr <= 3'b010;
    @(posedge i_ref_clk);
    herr <= 3'b000;
    chk_rd(`IRQ_OFF_STATUS, 32'hC1);
    wr(`IRQ_OFF_ENABLE, 32'h00);
    chk_rd(`IRQ_OFF_LINE_STATUS, 32'h01);
    `CHK(o_irq, 1'b0)
  endtask : line_errors

  task automatic enhanced;
    wr(`IRQ_OFF_ENABLE, 32'hA0);
    chk_rd(`IRQ_OFF_ENABLE, 32'hA0);
    cts <= 1'b1;
    @(posedge i_ref_clk);
    cts <= 1'b0;
    chk_rd(`IRQ_OFF_STATUS, 32'hC1);
    wr(`IRQ_OFF_ENH_FUNC, 32'h90);
    cts <= 1'b1;
    @(posedge i_ref_clk);
    chk_rd(`IRQ_OFF_STATUS, 32'hE0);
    chk_rd(`IRQ_OFF_MODEM_STATUS, 32'h00);
    chk_rd(`IRQ_OFF_STATUS, 32'hC1);
    special <= 1'b1;
    @(posedge i_ref_clk);
    special <= 1'b0;
    chk_rd(`IRQ_OFF_STATUS, 32'hD0);
    chk_rd(`IRQ_OFF_STATUS, 32'hC1);
    wr(`IRQ_OFF_ENABLE, 32'hB0);
    `CHK(o_sleep_en, 1'b1)
    wr(`IRQ_OFF_FIFO_CTRL, 32'h09);
    wake <= 1'b1;
    @(posedge i_ref_clk);
    wake <= 1'b0;
    repeat (2) @(posedge i_ref_clk);
    `CHK(o_irq, 1'b1)
    chk_rd(`IRQ_OFF_STATUS, 32'hC1);
    @(posedge i_ref_clk);
    `CHK(o_irq, 1'b0)
  endtask : enhanced

  // ************************************
  // verdict and run control
  // ************************************
  task automatic tally_and_finish;
    if (bad_count == 0 && comparisons > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : tally_and_finish

  always @(posedge i_ref_clk) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      bad_count++;
      tally_and_finish();
    end
  end

  initial begin
    repeat (12) @(posedge i_ref_clk);
    i_rst <= 1'b0;
    @(posedge i_ref_clk);
    reset_state();
    rx_trigger();
    tx_ready();
    priority_chain();
    rx_timeout();
    line_errors();
    enhanced();
    tally_and_finish();
  end
endmodule : uart_interrupt_prioritizer_test
